// ### hdl/gpz_mux.sv
`timescale 1ns/1ps

// What this block does
// - Bits 7:6 set pin drive strength
// - Bit 5 enables pull-up on inputs
// - Bits 4:0 select pin function
// - Code 00001 outputs power-on-reset
// - Low-battery function outputs detector level
// - Code 00011 samples pin as input
// - Codes 00100/5/6 fire pin interrupts
// - Code 00111 routes pin to ADC
// - Code 10000 takes transmit data input
// - Code 10010 outputs transmit state
// - Code 10011 outputs TX FIFO almost-full
// - Code 10111 outputs antenna 1 switch
// - Code 11001 outputs valid preamble
module gpz_mux
	import gpz_pkg::*;
#(
	parameter int ADDR_W = GPZ_AW
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [GPZ_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [GPZ_DW-1:0]      reg_rdata,
	input  wire gpz_core_t         core_in,
	input  wire logic              general_pin_zero_in,
	output logic                   general_pin_zero_out,
	output logic                   general_pin_zero_oe,
	output gpz_padctl_t            pad_ctl,
	output logic                   direct_in_level,
	output logic                   tx_mod_data,
	output logic                   ext_irq_pulse,
	output logic                   irq
);

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	generate
		if (ADDR_W < 5 || ADDR_W > GPZ_AW) begin : g_bad_aw
			$error("ADDR_W must lie between 5 and 8");
		end
	endgenerate

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [GPZ_DW-1:0] cfg_r;
	logic [GPZ_DW-1:0] irq_en_r;
	logic [GPZ_DW-1:0] irq_stat_r;
	logic [GPZ_DW-1:0] irq_stat_nxt;
	logic [GPZ_DW-1:0] rdata_r;
	logic [GPZ_DW-1:0] rdata_nxt;
	logic              out_r;
	logic              oe_r;
	logic              pup_r;
	logic              adc_r;
	logic              din_r;
	logic              txd_r;
	logic              ext_r;
	logic [7:0]        addr8;
	logic [4:0]        fn;
	logic              fn_in;
	logic              out_nxt;
	logic              oe_nxt;
	logic              pin_lvl;
	logic              pin_rise;
	logic              pin_fall;
	logic              ev_pin;
	logic              hit_cfg;
	logic              hit_stat;
	logic              hit_en;
	logic              hit_clr;

	// ------------------------------------------------------------
	// Pin input conditioning
	// ------------------------------------------------------------
	gpz_pin_sync u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin_in  (general_pin_zero_in),
		.level   (pin_lvl),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign addr8    = 8'(reg_addr);
	assign hit_cfg  = (addr8 == GPZ_OFS_CFG);
	assign hit_stat = (addr8 == GPZ_OFS_IRQ_STAT);
	assign hit_en   = (addr8 == GPZ_OFS_IRQ_EN);
	assign hit_clr  = (addr8 == GPZ_OFS_IRQ_CLR);

	// Writable registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_r    <= GPZ_CFG_RST;
			irq_en_r <= GPZ_IRQ_EN_RST;
		end else begin
			if (reg_wr && hit_cfg) begin
				cfg_r <= reg_wdata;
			end
			if (reg_wr && hit_en) begin
				irq_en_r <= reg_wdata & GPZ_IRQ_MASK;
			end
		end
	end

	// Read mux; unmapped and clear addresses read zero
	always_comb begin
		rdata_nxt = '0;
		if (!reg_rd) begin
			rdata_nxt = '0;
		end else if (hit_cfg) begin
			rdata_nxt = cfg_r;
		end else if (hit_stat) begin
			rdata_nxt = irq_stat_r;
		end else if (hit_en) begin
			rdata_nxt = irq_en_r;
		end else begin
			rdata_nxt = '0;
		end
	end

	// Read data stands in the cycle after each cycle of reg_rd
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end
	assign reg_rdata = rdata_r;

	// ------------------------------------------------------------
	// Function selection
	// ------------------------------------------------------------
	// function code field
	assign fn    = cfg_r[GPZ_FN_HI:0];
	assign fn_in = gpz_fn_is_input(fn);

	assign out_nxt =
		(fn == GPZ_FN_POR)      ? core_in.por          :
		(fn == GPZ_FN_LOWBAT)   ? core_in.low_bat      :
		(fn == GPZ_FN_TXSTATE)  ? core_in.tx_state     :
		(fn == GPZ_FN_TXAFULL)  ? core_in.txfifo_afull :
		(fn == GPZ_FN_ANT1)     ? core_in.ant1_sw      :
		(fn == GPZ_FN_PREAMBLE) ? core_in.preamble_ok  : 1'b0;

	// inputs and ADC release the pin
	assign oe_nxt = ~fn_in && (fn != GPZ_FN_ADC);

	assign ev_pin =
		((fn == GPZ_FN_IRQ_FALL) && pin_fall) ||
		((fn == GPZ_FN_IRQ_RISE) && pin_rise) ||
		((fn == GPZ_FN_IRQ_CHG) && (pin_rise || pin_fall));

	// Pin data and enable registered to avoid glitches
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_r <= 1'b0;
			oe_r  <= 1'b0;
			pup_r <= 1'b0;
			adc_r <= 1'b0;
			din_r <= 1'b0;
			txd_r <= 1'b0;
			ext_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
			oe_r  <= oe_nxt;
			pup_r <= cfg_r[GPZ_PUP_BIT] & fn_in;
			adc_r <= (fn == GPZ_FN_ADC);
			din_r <= (fn == GPZ_FN_DIN) ? pin_lvl : din_r;
			txd_r <= (fn == GPZ_FN_TXDATA) & pin_lvl;
			ext_r <= ev_pin;
		end
	end

	assign general_pin_zero_out = out_r;
	assign general_pin_zero_oe  = oe_r;
	assign pad_ctl.pin_drive_strength = cfg_r[GPZ_DRV_HI:GPZ_DRV_LO];
	assign pad_ctl.pin_pullup_enable  = pup_r;
	assign pad_ctl.adc_route          = adc_r;
	assign direct_in_level            = din_r;
	assign tx_mod_data                = txd_r;
	assign ext_irq_pulse              = ext_r;

	// ------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------
	// sticky pin event, set beats clear
	always_comb begin
		irq_stat_nxt = irq_stat_r;
		if (reg_wr && hit_clr) begin
			irq_stat_nxt = irq_stat_r & ~reg_wdata;
		end
		irq_stat_nxt[GPZ_IRQ_PIN_BIT] = irq_stat_nxt[GPZ_IRQ_PIN_BIT] | ev_pin;
		irq_stat_nxt = irq_stat_nxt & GPZ_IRQ_MASK;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// Level request while enabled status is set
	assign irq = |(irq_stat_r & irq_en_r);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Checks rest one extra cycle: reset may drop in the very edge
	// that still clears the registers, so $past would see stale state
	logic rst_dly_r;

	always_ff @(posedge clk) begin
		rst_dly_r <= sys_rst;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || rst_dly_r);

	chk_drive_write: assert property (
		(reg_wr && hit_cfg) |=>
		(pad_ctl.pin_drive_strength == $past(reg_wdata[GPZ_DRV_HI:GPZ_DRV_LO])))
		else $error("drive strength not taken from write");

	chk_pullup_gate: assert property (
		##1 (pad_ctl.pin_pullup_enable ==
		($past(cfg_r[GPZ_PUP_BIT]) && gpz_fn_is_input($past(fn)))))
		else $error("pull-up not gated by input mode");

	chk_por_out: assert property (
		(fn == GPZ_FN_POR) |=>
		(general_pin_zero_oe && general_pin_zero_out == $past(core_in.por)))
		else $error("power-on-reset not on pin");

	chk_lowbat_out: assert property (
		(fn == GPZ_FN_LOWBAT) |=>
		(general_pin_zero_oe && general_pin_zero_out == $past(core_in.low_bat)))
		else $error("low battery not on pin");

	chk_din_released: assert property (
		(fn == GPZ_FN_DIN) |=>
		(!general_pin_zero_oe && direct_in_level == $past(pin_lvl)))
		else $error("direct input not sampled");

	chk_rise_irq: assert property (
		((fn == GPZ_FN_IRQ_RISE) && pin_rise) |=>
		(ext_irq_pulse && irq_stat_r[GPZ_IRQ_PIN_BIT]) ##1 !ext_irq_pulse)
		else $error("rising edge interrupt lost");

	chk_fall_only: assert property (
		((fn == GPZ_FN_IRQ_FALL) && pin_rise) |=> !ext_irq_pulse)
		else $error("falling mode fired on rise");

	chk_adc_route: assert property (
		(fn == GPZ_FN_ADC) |=> (pad_ctl.adc_route && !general_pin_zero_oe))
		else $error("adc route not set");

	chk_txdata_in: assert property (
		(fn == GPZ_FN_TXDATA) |=> (tx_mod_data == $past(pin_lvl)))
		else $error("transmit data not passed");

	chk_txstate_out: assert property (
		(fn == GPZ_FN_TXSTATE) |=> (general_pin_zero_out == $past(core_in.tx_state)))
		else $error("tx state not on pin");

	chk_afull_out: assert property (
		(fn == GPZ_FN_TXAFULL) |=>
		(general_pin_zero_out == $past(core_in.txfifo_afull)))
		else $error("fifo almost full not on pin");

	chk_ant1_out: assert property (
		(fn == GPZ_FN_ANT1) |=> (general_pin_zero_out == $past(core_in.ant1_sw)))
		else $error("antenna switch not on pin");

	chk_preamble_out: assert property (
		(fn == GPZ_FN_PREAMBLE) |=>
		(general_pin_zero_out == $past(core_in.preamble_ok)))
		else $error("preamble detect not on pin");

	chk_undef_low: assert property (
		(fn == 5'h08 || fn == 5'h1F || fn == 5'h00) |=>
		(general_pin_zero_oe && !general_pin_zero_out))
		else $error("undefined code not driven low");

	chk_cfg_readback: assert property (
		(reg_rd && hit_cfg) |=> (reg_rdata == $past(cfg_r)) ##1 (reg_rdata == '0 || $past(reg_rd)))
		else $error("config read wrong");

	cov_rise_irq: cover property (
		(fn == GPZ_FN_IRQ_RISE) && pin_rise ##1 irq);
	cov_chg_irq: cover property ((fn == GPZ_FN_IRQ_CHG) && pin_fall);
	cov_txdata: cover property ((fn == GPZ_FN_TXDATA) && pin_rise);
	cov_set_clr: cover property (ev_pin && reg_wr && hit_clr);

endmodule

// ### hdl/gpz_pkg.sv
package gpz_pkg;

	// ------------------------------------------------------------
	// Register map and bus widths
	// ------------------------------------------------------------
	localparam int        GPZ_AW           = 8;
	localparam int        GPZ_DW           = 8;
	localparam logic [7:0] GPZ_OFS_CFG     = 8'h0B;
	localparam logic [7:0] GPZ_OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] GPZ_OFS_IRQ_EN  = 8'h11;
	localparam logic [7:0] GPZ_OFS_IRQ_CLR = 8'h12;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int        GPZ_DRV_HI       = 7;
	localparam int        GPZ_DRV_LO       = 6;
	localparam int        GPZ_PUP_BIT      = 5;
	localparam int        GPZ_FN_HI        = 4;
	localparam int        GPZ_IRQ_PIN_BIT  = 0;
	localparam logic [7:0] GPZ_CFG_RST     = 8'h00;
	localparam logic [7:0] GPZ_IRQ_EN_RST  = 8'h00;
	localparam logic [7:0] GPZ_IRQ_MASK    = 8'h01;

	// ------------------------------------------------------------
	// Pin function codes
	// ------------------------------------------------------------
	localparam logic [4:0] GPZ_FN_POR      = 5'h01;
	localparam logic [4:0] GPZ_FN_LOWBAT   = 5'h02;
	localparam logic [4:0] GPZ_FN_DIN      = 5'h03;
	localparam logic [4:0] GPZ_FN_IRQ_FALL = 5'h04;
	localparam logic [4:0] GPZ_FN_IRQ_RISE = 5'h05;
	localparam logic [4:0] GPZ_FN_IRQ_CHG  = 5'h06;
	localparam logic [4:0] GPZ_FN_ADC      = 5'h07;
	localparam logic [4:0] GPZ_FN_TXDATA   = 5'h10;
	localparam logic [4:0] GPZ_FN_TXSTATE  = 5'h12;
	localparam logic [4:0] GPZ_FN_TXAFULL  = 5'h13;
	localparam logic [4:0] GPZ_FN_ANT1     = 5'h17;
	localparam logic [4:0] GPZ_FN_PREAMBLE = 5'h19;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	// Internal indications offered to the pin
	typedef struct packed {
		logic por;
		logic low_bat;
		logic tx_state;
		logic txfifo_afull;
		logic ant1_sw;
		logic preamble_ok;
	} gpz_core_t;

	// Pin-facing controls besides data and enable
	typedef struct packed {
		logic [1:0] pin_drive_strength;
		logic       pin_pullup_enable;
		logic       adc_route;
	} gpz_padctl_t;

	// Digital input functions of the pin
	function automatic logic gpz_fn_is_input(input logic [4:0] f);
		gpz_fn_is_input = (f == GPZ_FN_DIN) || (f == GPZ_FN_IRQ_FALL) ||
			(f == GPZ_FN_IRQ_RISE) || (f == GPZ_FN_IRQ_CHG) ||
			(f == GPZ_FN_TXDATA);
	endfunction

endpackage

// ### hdl/gpz_pin_sync.sv
`timescale 1ns/1ps

module gpz_pin_sync (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pin_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	// ------------------------------------------------------------
	// Three-stage synchroniser
	// ------------------------------------------------------------
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic lvl_r;
	logic agree;
	logic lvl_nxt;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Level moves only when late stages agree
	assign agree   = (s2_r == s3_r);
	assign lvl_nxt = agree ? s3_r : lvl_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lvl_r <= 1'b0;
		end else begin
			lvl_r <= lvl_nxt;
		end
	end

	// Edges are one-cycle pulses on the accepted level
	assign level = lvl_r;
	assign rise  = lvl_nxt & ~lvl_r;
	assign fall  = ~lvl_nxt & lvl_r;

endmodule

// ### test/gpz_pin_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Outside circuitry on the pin
// ------------------------------------------------------------
module gpz_pin_model (
	input  wire logic clk,
	input  wire logic dev_out,
	input  wire logic dev_oe,
	input  wire logic pullup_on,
	input  wire logic ext_drive,
	input  wire logic ext_val,
	output logic      pin_level
);
	logic churn_r = 1'b0;

	// A floating pin wanders, so nothing may lean on its last level
	always_ff @(posedge clk) begin
		churn_r <= ~churn_r;
	end

	// Wire level: device first, then our driver, then pull-up
	assign pin_level = dev_oe ? dev_out : ext_drive ? ext_val : pullup_on ? 1'b1 : churn_r;
endmodule

// ### test/gpz_mux_tb.sv
`timescale 1ns/1ps

module gpz_mux_tb;
	import gpz_pkg::*;

	typedef struct packed {
		logic [4:0] code;
		logic [5:0] mask;
		logic       oe;
		logic       inp;
		logic       adc;
	} gpz_row_t;

	logic        clk, sys_rst, reg_wr, reg_rd, ext_drive, ext_val, pin_in;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	gpz_core_t   core_in;
	gpz_padctl_t pad_ctl;
	logic        pin_out, pin_oe, direct_in_level, tx_mod_data, ext_irq_pulse, irq;
	int          n_errors = 0;
	int          checked  = 0;

	// Ordinary cases: function, source bit, drives, input, analog
	gpz_row_t rows [0:14] = '{
		'{GPZ_FN_POR,      6'h20, 1'b1, 1'b0, 1'b0},
		'{GPZ_FN_LOWBAT,   6'h10, 1'b1, 1'b0, 1'b0},
		'{GPZ_FN_TXSTATE,  6'h08, 1'b1, 1'b0, 1'b0},
		'{GPZ_FN_TXAFULL,  6'h04, 1'b1, 1'b0, 1'b0},
		'{GPZ_FN_ANT1,     6'h02, 1'b1, 1'b0, 1'b0},
		'{GPZ_FN_PREAMBLE, 6'h01, 1'b1, 1'b0, 1'b0},
		'{5'h00,           6'h00, 1'b1, 1'b0, 1'b0},
		'{5'h08,           6'h00, 1'b1, 1'b0, 1'b0},
		'{5'h1F,           6'h00, 1'b1, 1'b0, 1'b0},
		'{GPZ_FN_DIN,      6'h00, 1'b0, 1'b1, 1'b0},
		'{GPZ_FN_IRQ_FALL, 6'h00, 1'b0, 1'b1, 1'b0},
		'{GPZ_FN_IRQ_RISE, 6'h00, 1'b0, 1'b1, 1'b0},
		'{GPZ_FN_IRQ_CHG,  6'h00, 1'b0, 1'b1, 1'b0},
		'{GPZ_FN_TXDATA,   6'h00, 1'b0, 1'b1, 1'b0},
		'{GPZ_FN_ADC,      6'h00, 1'b0, 1'b0, 1'b1}
	};

	gpz_mux i_gpz_mux (
		.clk                  (clk),
		.sys_rst              (sys_rst),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_rdata            (reg_rdata),
		.core_in              (core_in),
		.general_pin_zero_in  (pin_in),
		.general_pin_zero_out (pin_out),
		.general_pin_zero_oe  (pin_oe),
		.pad_ctl              (pad_ctl),
		.direct_in_level      (direct_in_level),
		.tx_mod_data          (tx_mod_data),
		.ext_irq_pulse        (ext_irq_pulse),
		.irq                  (irq)
	);

	gpz_pin_model i_gpz_pin_model (
		.clk       (clk),
		.dev_out   (pin_out),
		.dev_oe    (pin_oe),
		.pullup_on (pad_ctl.pin_pullup_enable),
		.ext_drive (ext_drive),
		.ext_val   (ext_val),
		.pin_level (pin_in)
	);

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		chk("rdata", reg_rdata, exp);
	endtask

	// Moves the pin and counts interrupt pulses over the sync delay
	task automatic pin_edge(input logic v, input int exp_n);
		int n;
		n = 0;
		@(posedge clk);
		ext_val <= v;
		repeat (8) begin
			@(posedge clk);
			#1;
			if (ext_irq_pulse === 1'b1) n++;
		end
		chk("pulses", n[7:0], exp_n[7:0]);
	endtask

	task automatic finish_test;
		if (n_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Watchdog well beyond the expected run of about 290 cycles
	initial begin
		#100000;
		n_errors++;
		finish_test;
	end

	initial begin
		{sys_rst, reg_wr, reg_rd, ext_drive, ext_val} <= 5'b10010;
		{reg_addr, reg_wdata} <= 16'h0000;
		core_in <= 6'h00;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("rst_oe", pin_oe, 1'h1);
		chk("rst_out", pin_out, 1'h0);
		chk("rst_irq", irq, 1'h0);
		chk("rst_pad", pad_ctl, 4'h0);
		rd(GPZ_OFS_CFG, GPZ_CFG_RST);
		rd(GPZ_OFS_IRQ_EN, GPZ_IRQ_EN_RST);
		rd(8'h20, 8'h00);
		// Every selectable function, source high then low
		for (int i = 0; i < 15; i++) begin
			wr(GPZ_OFS_CFG, {2'b10, 1'b1, rows[i].code});
			core_in <= rows[i].mask;
			repeat (2) @(posedge clk);
			#1;
			chk("oe", pin_oe, rows[i].oe);
			if (rows[i].oe) chk("out", pin_out, |rows[i].mask);
			chk("adc", pad_ctl.adc_route, rows[i].adc);
			chk("pullup", pad_ctl.pin_pullup_enable, rows[i].inp);
			chk("drive", pad_ctl.pin_drive_strength, 2'b10);
			rd(GPZ_OFS_CFG, {2'b10, 1'b1, rows[i].code});
			@(posedge clk);
			core_in <= ~rows[i].mask;
			repeat (2) @(posedge clk);
			#1;
			if (rows[i].oe) chk("out_inv", pin_out, 1'h0);
		end
		// Edge interrupts: rise, fall, change, masked
		wr(GPZ_OFS_IRQ_EN, 8'h01);
		wr(GPZ_OFS_CFG, {3'b000, GPZ_FN_IRQ_RISE});
		pin_edge(1'b1, 1);
		chk("irq_on", irq, 1'h1);
		rd(GPZ_OFS_IRQ_STAT, 8'h01);
		wr(GPZ_OFS_IRQ_CLR, 8'h01);
		#1;
		chk("irq_off", irq, 1'h0);
		pin_edge(1'b0, 0);
		wr(GPZ_OFS_CFG, {3'b000, GPZ_FN_IRQ_FALL});
		pin_edge(1'b1, 0);
		pin_edge(1'b0, 1);
		wr(GPZ_OFS_CFG, {3'b000, GPZ_FN_IRQ_CHG});
		pin_edge(1'b1, 1);
		wr(GPZ_OFS_IRQ_EN, 8'h00);
		pin_edge(1'b0, 1);
		chk("irq_mask", irq, 1'h0);
		rd(GPZ_OFS_IRQ_STAT, 8'h01);
		wr(GPZ_OFS_IRQ_CLR, 8'h01);
		wr(GPZ_OFS_IRQ_STAT, 8'h01);
		rd(GPZ_OFS_IRQ_STAT, 8'h00);
		// Direct input and transmit data, no pulses
		wr(GPZ_OFS_CFG, {3'b000, GPZ_FN_DIN});
		pin_edge(1'b1, 0);
		chk("din", direct_in_level, 1'h1);
		wr(GPZ_OFS_CFG, {3'b000, GPZ_FN_TXDATA});
		pin_edge(1'b0, 0);
		chk("txd0", tx_mod_data, 1'h0);
		pin_edge(1'b1, 0);
		chk("txd1", tx_mod_data, 1'h1);
		// Released pin held high only by the pull-up
		wr(GPZ_OFS_CFG, {3'b001, GPZ_FN_DIN});
		pin_edge(1'b0, 0);
		chk("din0", direct_in_level, 1'h0);
		@(posedge clk);
		ext_drive <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk("pullup_hi", direct_in_level, 1'h1);
		// Reset in mid-run restores the configuration
		@(posedge clk);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		rd(GPZ_OFS_CFG, GPZ_CFG_RST);
		chk("rst2_pad", pad_ctl, 4'h0);
		chk("rst2_oe", pin_oe, 1'h1);
		finish_test;
	end
endmodule
